/* rtl/tlih_pkg.sv */
/*
 * Constants for the two-level interrupt handler: source count, source order,
 * vector addresses and timing of the call sequence.
 * Assumes a single system clock at 20 MHz and an active-low async reset.
 */
package tlih_pkg;
    localparam int NUM_SRC = 12;
    localparam int SRC_W = 4;
    localparam int VEC_W = 16;
    // Source positions in fixed order, 0 wins among equals
    localparam logic [SRC_W-1:0] SRC_PIN_A = 4'h0;
    localparam logic [SRC_W-1:0] SRC_PIN_B = 4'h2;
    // Vector = base + index * stride
    localparam logic [VEC_W-1:0] VEC_BASE = 16'h0003;
    localparam logic [VEC_W-1:0] VEC_STRIDE = 16'h0008;
    // Reset values
    localparam logic [NUM_SRC-1:0] PRIO_RESET = 12'h000;
    localparam logic [NUM_SRC-1:0] ENABLE_RESET = 12'h000;
    // Timing: one detect cycle, then a four-cycle long call
    localparam int CLK_HZ = 20000000;
    localparam int DETECT_CYCLES = 1;
    localparam int CALL_CYCLES = 4;
    localparam int RESPONSE_CYCLES = DETECT_CYCLES + CALL_CYCLES;
    localparam logic [2:0] CALL_LAST = 3'(CALL_CYCLES - 1);
    typedef enum {ST_RUN, ST_CALL, ST_RETI_WAIT} tlih_state_t;
endpackage

/* rtl/tlih_pin_sense.sv */
/*
 * Sense logic for one external interrupt pin: polarity, edge or level mode.
 * Assumes the pin is already synchronous to the clock.
 */
module tlih_pin_sense
(
    input wire logic clock,        // System clock
    input wire logic rst_n,        // Async reset, active low
    input wire logic pin,          // Assigned port pin, sampled only
    input wire logic polarity,     // 1 active high, 0 active low
    input wire logic triggerEdge,  // 1 edge, 0 level
    output logic active,           // Level seen at selected polarity
    output logic edgeSeen          // One-cycle pulse on active edge
);
    logic prevActive;

    // ************************************************************
    // Polarity and edge detection
    // ************************************************************
    assign active = (pin == polarity);
    assign edgeSeen = triggerEdge & active & ~prevActive;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            prevActive <= 1'b0;
        else
            prevActive <= active;
    end
endmodule

/* rtl/tlih_handler.sv */
/*
 * Two-level interrupt handler: pending flags, enables, priority arbitration,
 * vector call request, return handling and preemption.
 * Assumes the core pulses instrDone at each instruction end, retiDone when a
 * return-from-interrupt finishes, and callAck on each cycle of the long call.
 */
module tlih_handler
    import tlih_pkg::*;
#(
    parameter int NSRC = tlih_pkg::NUM_SRC
)
(
    input wire logic clock,                          // System clock
    input wire logic rst_n,                          // Async reset, active low
    input wire logic [NSRC-1:0] srcEvent,            // Peripheral valid-condition pulses
    input wire logic [NSRC-1:0] hwClearOnVector,     // Flags cleared when vectored
    input wire logic [NSRC-1:0] swFlagSet,           // Software write of one to a flag
    input wire logic [NSRC-1:0] swFlagClear,         // Software write of zero to a flag
    input wire logic global_irq_enable,              // Global enable bit
    input wire logic globalEnableClearing,           // Instruction clearing global enable
    input wire logic nextIsSingleCycle,              // Following instruction is one cycle
    input wire logic [NSRC-1:0] sourceEnable,        // Individual enables, fixed order
    input wire logic [NSRC-1:0] sourcePriority,      // 1 high, fixed order
    input wire logic ext_irq_pin_a,                  // Pin for first external input
    input wire logic ext_irq_pin_b,                  // Pin for second external input
    input wire logic pin0_trigger_select,            // 1 edge, 0 level
    input wire logic pin1_trigger_select,            // 1 edge, 0 level
    input wire logic pin0_polarity,                  // 1 active high
    input wire logic pin1_polarity,                  // 1 active high
    input wire logic instrDone,                      // Current instruction completes
    input wire logic retiDone,                       // Return instruction completes
    input wire logic callAck,                        // Core running a call cycle
    output logic irqRequest,                         // Request to the core
    output logic callStart,                          // Pulse: begin long call now
    output logic [tlih_pkg::VEC_W-1:0] callVector,   // Address to call
    output logic [tlih_pkg::SRC_W-1:0] callSource,   // Source being served
    output logic [NSRC-1:0] pendingFlag,             // Pending flags
    output logic inHighHandler,                      // High handler running
    output logic inLowHandler                        // Low handler running
);
    logic [NSRC-1:0] next_pending;
    logic [NSRC-1:0] extEvent;
    logic [NSRC-1:0] levelMask;
    logic [NSRC-1:0] levelValue;
    logic [NSRC-1:0] vectorClear;
    logic [NSRC-1:0] gated;
    logic pinAActive;
    logic pinBActive;
    logic pinAEdge;
    logic pinBEdge;
    logic winValid;
    logic winHigh;
    logic [SRC_W-1:0] winIdx;
    logic gateOpen;
    logic allowed;
    logic takeNow;
    logic [NSRC-1:0] prioLevel;
    logic [2:0] callCount;
    tlih_state_t state;

    // ************************************************************
    // External pin sensing
    // ************************************************************
    tlih_pin_sense pinA
    (
        .clock(clock),
        .rst_n(rst_n),
        .pin(ext_irq_pin_a),
        .polarity(pin0_polarity),
        .triggerEdge(pin0_trigger_select),
        .active(pinAActive),
        .edgeSeen(pinAEdge)
    );

    tlih_pin_sense pinB
    (
        .clock(clock),
        .rst_n(rst_n),
        .pin(ext_irq_pin_b),
        .polarity(pin1_polarity),
        .triggerEdge(pin1_trigger_select),
        .active(pinBActive),
        .edgeSeen(pinBEdge)
    );

    // ************************************************************
    // Pending flags
    // ************************************************************
    always_comb
    begin
        extEvent = '0;
        levelMask = '0;
        levelValue = '0;
        extEvent[SRC_PIN_A] = pinAEdge;
        extEvent[SRC_PIN_B] = pinBEdge;
        levelMask[SRC_PIN_A] = ~pin0_trigger_select;
        levelMask[SRC_PIN_B] = ~pin1_trigger_select;
        levelValue[SRC_PIN_A] = pinAActive;
        levelValue[SRC_PIN_B] = pinBActive;
    end

    genvar g;
    generate
        for (g = 0; g < NSRC; g++)
        begin : flagBit
            always_comb
            begin
                vectorClear[g] = callStart && (callSource == SRC_W'(g))
                    && hwClearOnVector[g];
                if (levelMask[g])
                    next_pending[g] = levelValue[g] | swFlagSet[g];
                else if (srcEvent[g] | extEvent[g] | swFlagSet[g])
                    next_pending[g] = 1'b1;
                else if (swFlagClear[g] | vectorClear[g])
                    next_pending[g] = 1'b0;
                else
                    next_pending[g] = pendingFlag[g];
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            pendingFlag <= '0;
        else
            pendingFlag <= next_pending;
    end

    // ************************************************************
    // Priority levels
    // ************************************************************
    // Registered copy so that every source starts at the low level
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            prioLevel <= NSRC'(PRIO_RESET);
        else
            prioLevel <= sourcePriority;
    end

    // ************************************************************
    // Arbitration: high level first, then fixed order
    // ************************************************************
    assign gated = pendingFlag & sourceEnable;

    always_comb
    begin
        winValid = 1'b0;
        winHigh = 1'b0;
        winIdx = '0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (gated[i] && prioLevel[i])
            begin
                winValid = 1'b1;
                winHigh = 1'b1;
                winIdx = SRC_W'(i);
            end
        end
        if (!winValid)
        begin
            for (int i = NSRC - 1; i >= 0; i--)
            begin
                if (gated[i])
                begin
                    winValid = 1'b1;
                    winIdx = SRC_W'(i);
                end
            end
        end
    end

    // Late clear of global enable still lets a call through before a 1-cycle op
    assign gateOpen = global_irq_enable
        | (globalEnableClearing & nextIsSingleCycle);
    // Preemption: only high over running low; nothing over high
    assign allowed = !inHighHandler && (winHigh || !inLowHandler);
    // A return's own edge never starts a call; the next instruction end may
    assign takeNow = gateOpen && winValid && allowed && instrDone && !retiDone
        && (state == ST_RUN || state == ST_RETI_WAIT);

    // ************************************************************
    // Request and call sequencing
    // ************************************************************
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            irqRequest <= 1'b0;
        else
            irqRequest <= gateOpen && winValid && allowed;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            state <= ST_RUN;
        else
        begin
            case (state)
                ST_RUN:
                begin
                    if (retiDone)
                        state <= ST_RETI_WAIT;
                    else if (takeNow)
                        state <= ST_CALL;
                end
                ST_CALL:
                begin
                    if (callAck && callCount == CALL_LAST)
                        state <= ST_RUN;
                end
                ST_RETI_WAIT:
                begin
                    // The one instruction after a return may end straight in a call
                    if (takeNow)
                        state <= ST_CALL;
                    else if (instrDone)
                        state <= ST_RUN;
                end
                default:
                    state <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            callStart <= 1'b0;
            callVector <= '0;
            callSource <= '0;
        end
        else
        begin
            callStart <= takeNow;
            if (takeNow)
            begin
                callSource <= winIdx;
                callVector <= VEC_BASE + VEC_W'(winIdx) * VEC_STRIDE;
            end
        end
    end

    // Counts the acknowledged cycles of the long call
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            callCount <= '0;
        else if (takeNow)
            callCount <= '0;
        else if (state == ST_CALL && callAck)
            callCount <= callCount + 3'h1;
    end

    // ************************************************************
    // Active handler levels
    // ************************************************************
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            inHighHandler <= 1'b0;
            inLowHandler <= 1'b0;
        end
        else if (callStart)
        begin
            if (prioLevel[callSource])
                inHighHandler <= 1'b1;
            else
                inLowHandler <= 1'b1;
        end
        else if (retiDone)
        begin
            if (inHighHandler)
                inHighHandler <= 1'b0;
            else
                inLowHandler <= 1'b0;
        end
    end
endmodule

/* testbench/tlih_core_model.sv */
/*
 * Core model: instruction ends, return ends and the four call cycles.
 * Assumes the bench pulses retiReq for one cycle while no call runs.
 */
module tlih_core_model
(
    input wire logic clock, // Clock
    input wire logic rst_n, // Reset
    input wire logic callStart, // Call begins
    input wire logic retiReq, // Return now
    input wire logic slow, // Longer instructions
    output logic instrDone, // Instruction end
    output logic retiDone, // Return end
    output logic callAck // Call cycle
);
    logic [2:0] ackLeft;
    logic [1:0] cnt;
    always_ff @(negedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ackLeft <= 3'h0;
            cnt <= 2'h0;
        end
        else
        begin
            cnt <= cnt + 2'h1;
            if (callStart && ackLeft == 3'h0)
                ackLeft <= 3'h4;
            else if (ackLeft != 3'h0)
                ackLeft <= ackLeft - 3'h1;
        end
    end
    assign callAck = ackLeft != 3'h0;
    assign retiDone = retiReq;
    // No instruction ends during a call or a return
    assign instrDone = !callAck && !retiReq && (slow ? cnt == 2'h0 : !cnt[0]);
endmodule

/* testbench/tlih_handler_properties.sv */
/*
 * Checker for the interrupt handler, watching its top ports only.
 * Assumes the bench keeps hwClearOnVector steady around each call.
 */
module tlih_handler_checker
    import tlih_pkg::*;
#(
    parameter int NSRC = tlih_pkg::NUM_SRC
)
(
    input wire logic clock, // Clock
    input wire logic rst_n, // Reset
    input wire logic [NSRC-1:0] srcEvent, // Events
    input wire logic [NSRC-1:0] hwClearOnVector, // Clear on vector
    input wire logic global_irq_enable, // Global enable
    input wire logic globalEnableClearing, // Enable clearing
    input wire logic nextIsSingleCycle, // Short next
    input wire logic [NSRC-1:0] sourceEnable, // Enables
    input wire logic instrDone, // Instruction end
    input wire logic retiDone, // Return end
    input wire logic irqRequest, // Request
    input wire logic callStart, // Call pulse
    input wire logic [tlih_pkg::VEC_W-1:0] callVector, // Vector
    input wire logic [tlih_pkg::SRC_W-1:0] callSource, // Source
    input wire logic [NSRC-1:0] pendingFlag, // Flags
    input wire logic inHighHandler // High running
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // ****************************************
    // Peripheral events of last cycle, pins out
    // ****************************************
    logic [NSRC-1:0] evtSeen;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            evtSeen <= {NSRC{1'h0}};
        else
            evtSeen <= srcEvent & ~hwClearOnVector & NSRC'(12'hffa);
    end
    sequence s_retHold;
        retiDone ##1 !instrDone [*3];
    endsequence
    property p_flagSet;
        |evtSeen |-> (pendingFlag & evtSeen) == evtSeen;
    endproperty
    a_flagSet: assert property (p_flagSet) else $error("flag not set");
    property p_gateShut;
        !global_irq_enable && !(globalEnableClearing && nextIsSingleCycle) |=> !irqRequest;
    endproperty
    a_gateShut: assert property (p_gateShut) else $error("request with gate shut");
    property p_noSrc;
        sourceEnable == {NSRC{1'h0}} |=> !irqRequest;
    endproperty
    a_noSrc: assert property (p_noSrc) else $error("request with no enable");
    property p_callCause;
        $rose(callStart) |-> $past(instrDone) && irqRequest;
    endproperty
    a_callCause: assert property (p_callCause) else $error("call without cause");
    property p_pulse;
        callStart |=> !callStart;
    endproperty
    a_pulse: assert property (p_pulse) else $error("call pulse too long");
    property p_vector;
        callStart |-> callVector == VEC_BASE + VEC_STRIDE * VEC_W'(callSource);
    endproperty
    a_vector: assert property (p_vector) else $error("wrong vector");
    property p_hwClear;
        callStart && hwClearOnVector[callSource] |=> !pendingFlag[callSource];
    endproperty
    a_hwClear: assert property (p_hwClear) else $error("flag kept on vector");
    property p_highNoPreempt;
        inHighHandler |-> !callStart;
    endproperty
    a_highNoPreempt: assert property (p_highNoPreempt) else $error("high preempted");
    property p_retHold;
        s_retHold |=> !callStart;
    endproperty
    a_retHold: assert property (p_retHold) else $error("call too soon");
endmodule
bind tlih_handler tlih_handler_checker #(.NSRC(NSRC)) u_checker (
    .clock, .rst_n, .srcEvent, .hwClearOnVector, .global_irq_enable, .globalEnableClearing,
    .nextIsSingleCycle, .sourceEnable, .instrDone, .retiDone, .irqRequest, .callStart,
    .callVector, .callSource, .pendingFlag, .inHighHandler
);

/* testbench/tb.sv */
/*
 * Bench for the interrupt handler with a core model on its far side.
 * Assumes the checker binds itself to the handler.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tlih_pkg::*;
    logic clock = 1'h0, rst_n = 1'h0, retiReq = 1'h0, slow = 1'h0;
    logic [11:0] srcEvent = 12'h000, hwClearOnVector = 12'h000, swFlagSet = 12'h000;
    logic [11:0] swFlagClear = 12'h000, sourceEnable = 12'h000, sourcePriority = 12'h000;
    logic global_irq_enable = 1'h0, globalEnableClearing = 1'h0, nextIsSingleCycle = 1'h0;
    logic ext_irq_pin_a = 1'h1, ext_irq_pin_b = 1'h1, pin0_trigger_select = 1'h0;
    logic pin1_trigger_select = 1'h0, pin0_polarity = 1'h0, pin1_polarity = 1'h0;
    logic instrDone, retiDone, callAck, irqRequest, callStart, inHighHandler, inLowHandler;
    logic [11:0] pendingFlag;
    logic [15:0] callVector;
    logic [3:0] callSource;
    int n_errors = 0, n_compared = 0;
    always #25 clock = ~clock;
    tlih_handler #(.NSRC(NUM_SRC)) uut (
        .clock, .rst_n, .srcEvent, .hwClearOnVector, .swFlagSet, .swFlagClear,
        .global_irq_enable, .globalEnableClearing, .nextIsSingleCycle, .sourceEnable,
        .sourcePriority, .ext_irq_pin_a, .ext_irq_pin_b, .pin0_trigger_select,
        .pin1_trigger_select, .pin0_polarity, .pin1_polarity, .instrDone, .retiDone,
        .callAck, .irqRequest, .callStart, .callVector, .callSource, .pendingFlag,
        .inHighHandler, .inLowHandler
    );
    tlih_core_model core (
        .clock, .rst_n, .callStart, .retiReq, .slow, .instrDone, .retiDone, .callAck
    );
    // ****************************************
    // Tasks
    // ****************************************
    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_compared++;
        if (got !== exp)
        begin
            $display("[ERR] %0t %s", $time, m);
            n_errors++;
        end
    endtask
    task automatic ev(input logic [11:0] e, input logic [11:0] s, input logic [11:0] c);
        @(negedge clock);
        srcEvent = e;
        swFlagSet = s;
        swFlagClear = c;
        @(negedge clock);
        srcEvent = 12'h000;
        swFlagSet = 12'h000;
        swFlagClear = 12'h000;
    endtask
    // Waits for a call, checks it, then lets the four call cycles pass
    task automatic call(input logic [3:0] s);
        int i;
        for (i = 0; i < 40 && callStart !== 1'h1; i++)
            @(negedge clock);
        if (i == 40)
        begin
            $display("[ERR] %0t no call", $time);
            n_errors++;
            finish_test();
        end
        chk({12'h000, callSource}, {12'h000, s}, "source");
        chk(callVector, VEC_BASE + VEC_STRIDE * {12'h000, s}, "vector");
        repeat (5) @(negedge clock);
    endtask
    task automatic none();
        repeat (20)
        begin
            @(negedge clock);
            chk({15'h0000, callStart}, 16'h0000, "unexpected call");
        end
    endtask
    task automatic reti();
        @(negedge clock);
        retiReq = 1'h1;
        @(negedge clock);
        retiReq = 1'h0;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        repeat (6) @(negedge clock);
        rst_n = 1'h1;
        @(negedge clock);
        chk({inHighHandler, inLowHandler, irqRequest, callStart, pendingFlag}, 16'h0000, "reset");
        global_irq_enable = 1'h1;
        ev(12'h020, 12'h000, 12'h000);
        chk({4'h0, pendingFlag}, 16'h0020, "flag set");
        none();
        sourceEnable = 12'h020;
        global_irq_enable = 1'h0;
        none();
        global_irq_enable = 1'h1;
        call(4'h5);
        chk({4'h0, pendingFlag}, 16'h0020, "flag kept");
        ev(12'h000, 12'h000, 12'h020);
        reti();
        none();
        $display("test enables done");
        sourceEnable = 12'hfff;
        slow = 1'h1;
        ev(12'h088, 12'h000, 12'h000);
        call(4'h3);
        ev(12'h000, 12'h000, 12'h008);
        reti();
        call(4'h7);
        ev(12'h000, 12'h000, 12'h080);
        reti();
        slow = 1'h0;
        $display("test order done");
        sourcePriority = 12'ha00;
        ev(12'h802, 12'h000, 12'h000);
        call(4'hb);
        ev(12'h000, 12'h000, 12'h800);
        reti();
        call(4'h1);
        ev(12'h200, 12'h000, 12'h000);
        call(4'h9);
        chk({14'h0000, inHighHandler, inLowHandler}, 16'h0003, "nested");
        ev(12'h800, 12'h000, 12'h000);
        none();
        ev(12'h000, 12'h000, 12'hfff);
        reti();
        reti();
        none();
        sourcePriority = 12'h000;
        $display("test priority done");
        global_irq_enable = 1'h0;
        globalEnableClearing = 1'h1;
        nextIsSingleCycle = 1'h1;
        ev(12'h000, 12'h010, 12'h000);
        call(4'h4);
        nextIsSingleCycle = 1'h0;
        ev(12'h000, 12'h000, 12'h010);
        reti();
        ev(12'h000, 12'h010, 12'h000);
        none();
        globalEnableClearing = 1'h0;
        ev(12'h000, 12'h000, 12'h010);
        global_irq_enable = 1'h1;
        $display("test global clear done");
        for (int c = 0; c < 4; c++)
        begin
            sourceEnable = 12'h000;
            {pin0_trigger_select, pin0_polarity} = 2'(c);
            {pin1_trigger_select, pin1_polarity} = 2'(c);
            hwClearOnVector = {9'h000, pin1_trigger_select, 1'h0, pin0_trigger_select};
            ext_irq_pin_a = !pin0_polarity;
            ext_irq_pin_b = !pin1_polarity;
            repeat (2) @(negedge clock);
            ev(12'h000, 12'h000, 12'h005);
            sourceEnable = 12'hfff;
            repeat (2) @(negedge clock);
            ext_irq_pin_a = pin0_polarity;
            ext_irq_pin_b = pin1_polarity;
            call(4'h0);
            chk({15'h0000, pendingFlag[0]}, {15'h0000, !pin0_trigger_select}, "pin");
            ext_irq_pin_a = !pin0_polarity;
            reti();
            call(4'h2);
            ext_irq_pin_b = !pin1_polarity;
            repeat (2) @(negedge clock);
            chk({4'h0, pendingFlag}, 16'h0000, "pins idle");
            reti();
        end
        $display("test pins done");
        finish_test();
    end
endmodule
